// file: dv/gdt_timer_tb_top.sv
// Self-checking bench for the guard timer: APB register tasks plus scripted scenarios.
// Assumes no fixed APB latency, waiting on pready, and that the chip resets the design after sys_reset_req.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module gdt_timer_tb_top;
  logic        clock;
  logic        rst_n;
  logic        ls_clk = 1'b0;
  logic [2:0]  pwr_mode;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sys_reset_req;
  logic        guard_irq;
  int          fails;
  int          total_checks;
  int          rises = 0;
  int          div = 0;
  int          mark;
  int          n;
  int          rst_count = 0;
  int          irq_cycles = 0;
  int          r0;

  gdt_timer u_dut (
    .clock         (clock),
    .rst_n         (rst_n),
    .ls_clk        (ls_clk),
    .pwr_mode      (pwr_mode),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .sys_reset_req (sys_reset_req),
    .guard_irq     (guard_irq)
  );

  // System clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Slow oscillator: 20 system clocks per period, wide enough for the two-write clear
  always @(posedge clock) begin
    if (div == 9) begin
      div    <= 0;
      ls_clk <= ~ls_clk;
      if (ls_clk == 1'b0) rises <= rises + 1;
    end else begin
      div <= div + 1;
    end
  end

  // Event monitors for the never-happens checks
  always @(posedge clock) begin
    if (sys_reset_req === 1'b1) rst_count <= rst_count + 1;
    if (guard_irq === 1'b1) irq_cycles <= irq_cycles + 1;
  end

  task automatic results;
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No assumed latency; a slave that never answers is caught by the run limit
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    `CHK(nm, exp, r)
    `CHK(nm, experr, e)
  endtask

  task automatic wait_rises(input int k);
    int m;
    m = rises;
    while (rises - m < k) @(posedge clock);
  endtask

  // Three system clocks after a slow falling edge, one before the design's sampled copy follows it,
  // so a two-write clear lands well inside one half period
  task automatic wait_fall;
    @(negedge ls_clk);
    repeat (3) @(posedge clock);
  endtask

  // Slow ticks from mark until the chosen output is seen high, -1 if it never comes
  task automatic wait_ev(input logic irq_side, output int cnt);
    int i;
    cnt = -1;
    for (i = 0; i < 40000; i++) begin
      @(posedge clock);
      if ((irq_side ? guard_irq : sys_reset_req) === 1'b1) begin
        cnt = rises - mark;
        break;
      end
    end
  endtask

  // Chip-level reset, as the system answers a watchdog timeout
  task automatic do_reset;
    @(posedge clock);
    rst_n    <= 1'b0;
    pwr_mode <= gdt_pkg::PWR_ACTIVE;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  // Run limit, about twice the expected length
  initial begin
    #3000000;
    fails++;
    results();
  end

  initial begin
    rst_n        = 1'b0;
    pwr_mode     = gdt_pkg::PWR_ACTIVE;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h00000000;
    fails        = 0;
    total_checks = 0;
    mark         = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    // Reset values, unmapped place, key ignored while disabled, no counting
    rd("ctrl reset", gdt_pkg::OFF_CTRL, 32'h00000000, 1'b0);
    rd("stat reset", gdt_pkg::OFF_STAT, 32'h00000000, 1'b0);
    rd("unmapped", 12'h008, 32'h00000000, 1'b1);
    wr(gdt_pkg::OFF_CTRL, 32'h000000a3);
    rd("key while off", gdt_pkg::OFF_CTRL, 32'h00000003, 1'b0);
    wait_rises(70);
    `CHK("no reset disabled", 0, rst_count)
    // Watchdog in power_mode_0: lock of enable and mode, 64-tick timeout
    pwr_mode <= gdt_pkg::PWR_MODE_0;
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000b);
    mark = rises;
    wr(gdt_pkg::OFF_CTRL, 32'h00000003);
    wr(gdt_pkg::OFF_CTRL, 32'h0000000f);
    rd("ctrl locked", gdt_pkg::OFF_CTRL, 32'h0000000b, 1'b0);
    wait_ev(1'b0, n);
    `CHK("wd ticks 64", 64, n)
    `CHK("no irq in wd", 0, irq_cycles)
    do_reset();
    // Wrong second key and late second key do not clear
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000b);
    mark = rises;
    wait_rises(20);
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h000000ab);
    wr(gdt_pkg::OFF_CTRL, 32'h0000006b);
    wait_rises(10);
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h000000ab);
    wait_rises(2);
    wr(gdt_pkg::OFF_CTRL, 32'h0000005b);
    wait_ev(1'b0, n);
    `CHK("bad clear", 64, n)
    do_reset();
    // Proper clear late in the interval restarts the count
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000b);
    wait_rises(50);
    wait_fall();
    mark = rises;
    wr(gdt_pkg::OFF_CTRL, 32'h000000ab);
    wr(gdt_pkg::OFF_CTRL, 32'h0000005b);
    wait_ev(1'b0, n);
    `CHK("good clear", 64, n)
    do_reset();
    // Interval change while locked, followed by a clear
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000b);
    wait_rises(10);
    wait_fall();
    mark = rises;
    wr(gdt_pkg::OFF_CTRL, 32'h000000aa);
    wr(gdt_pkg::OFF_CTRL, 32'h0000005a);
    wait_ev(1'b0, n);
    `CHK("interval 512", 512, n)
    do_reset();
    // Deep sleep clears the count and keeps the configuration
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000b);
    wait_rises(40);
    pwr_mode <= gdt_pkg::PWR_MODE_2;
    wait_rises(100);
    wait_fall();
    pwr_mode <= gdt_pkg::PWR_ACTIVE;
    mark = rises;
    rd("ctrl kept", gdt_pkg::OFF_CTRL, 32'h0000000b, 1'b0);
    wait_ev(1'b0, n);
    `CHK("after sleep", 64, n)
    do_reset();
    // power_mode_1: expiry held back, reset on return to active
    r0 = rst_count;
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000b);
    pwr_mode <= gdt_pkg::PWR_MODE_1;
    wait_rises(70);
    `CHK("no reset pm1", r0, rst_count)
    rd("stat expired", gdt_pkg::OFF_STAT, 32'h00000014, 1'b0);
    pwr_mode <= gdt_pkg::PWR_ACTIVE;
    mark = rises;
    wait_ev(1'b0, n);
    `CHK("reset on wake", 0, n)
    do_reset();
    // Timer mode: flag and interrupt, counter clear, stop and restart, masking
    r0 = rst_count;
    wr(gdt_pkg::OFF_STAT, 32'h00000002);
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000f);
    mark = rises;
    wait_ev(1'b1, n);
    `CHK("timer irq", 64, n)
    rd("stat flag", gdt_pkg::OFF_STAT, 32'h00000007, 1'b0);
    wr(gdt_pkg::OFF_STAT, 32'h00000003);
    rd("flag cleared", gdt_pkg::OFF_STAT, 32'h00000006, 1'b0);
    wait_rises(30);
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000001f);
    mark = rises;
    wait_ev(1'b1, n);
    `CHK("timer clear", 64, n)
    wr(gdt_pkg::OFF_STAT, 32'h00000003);
    wr(gdt_pkg::OFF_CTRL, 32'h00000007);
    wait_rises(70);
    rd("timer stopped", gdt_pkg::OFF_STAT, 32'h00000002, 1'b0);
    wait_fall();
    wr(gdt_pkg::OFF_CTRL, 32'h0000000f);
    mark = rises;
    wait_ev(1'b1, n);
    `CHK("timer restart", 64, n)
    wr(gdt_pkg::OFF_STAT, 32'h00000001);
    wait_rises(66);
    `CHK("irq masked", 1'b0, guard_irq)
    rd("flag masked", gdt_pkg::OFF_STAT, 32'h00000005, 1'b0);
    `CHK("no reset timer", r0, rst_count)
    results();
  end
endmodule

// file: inc/gdt_pkg.sv
// Shared constants and carrier types for the guard timer block.
// Assumes one 20 MHz system clock; the low-speed oscillator arrives as a sampled pin.
package gdt_pkg;

  // Register offsets (byte addresses on APB)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;

  // guard_ctrl field positions
  localparam int CTRL_KEY_LSB  = 4;
  localparam int CTRL_EN_BIT   = 3;
  localparam int CTRL_MODE_BIT = 2;
  localparam int CTRL_ISEL_LSB = 0;

  // guard_stat field positions
  localparam int STAT_FLAG_BIT  = 0;
  localparam int STAT_IEN_BIT   = 1;
  localparam int STAT_RUN_BIT   = 2;
  localparam int STAT_ARMED_BIT = 3;
  localparam int STAT_EXP_BIT   = 4;

  // Values after reset
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [14:0] CNT_RESET   = 15'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // Clear keys and modes
  localparam logic [3:0] KEY_FIRST  = 4'ha;
  localparam logic [3:0] KEY_SECOND = 4'h5;
  localparam logic       MODE_WDOG  = 1'b0;
  localparam logic       MODE_TIMER = 1'b1;

  // Terminal counts minus one, by interval_sel code
  localparam logic [14:0] TERM_SEL0 = 15'h7fff;  // 32768 periods
  localparam logic [14:0] TERM_SEL1 = 15'h1fff;  // 8192 periods
  localparam logic [14:0] TERM_SEL2 = 15'h01ff;  // 512 periods
  localparam logic [14:0] TERM_SEL3 = 15'h003f;  // 64 periods

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'h0,
    PWR_MODE_0 = 3'h1,
    PWR_MODE_1 = 3'h2,
    PWR_MODE_2 = 3'h3,
    PWR_MODE_3 = 3'h4
  } gdt_pwr_type;

  // Clear-sequence tracker
  typedef enum logic {
    KEY_IDLE  = 1'b0,
    KEY_ARMED = 1'b1
  } gdt_key_type;

  typedef struct packed {
    logic [3:0] key;
    logic       en;
    logic       mode;
    logic [1:0] isel;
  } gdt_ctrl_type;

  typedef struct packed {
    gdt_ctrl_type ctrl;
    logic         irq_flag;
    logic         irq_en;
    logic [14:0]  cnt;
    gdt_key_type  armed;
    logic         expired;
    logic         ls_prev;
    logic         rst_pulse;
    logic         irq;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } gdt_state_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } gdt_sync_type;

  typedef struct packed {
    logic r1;
    logic r2;
  } gdt_rsync_type;

  // Interval code to last count value before the terminal event
  function automatic logic [14:0] gdt_term(input logic [1:0] isel);
    case (isel)
      2'h0:    gdt_term = TERM_SEL0;
      2'h1:    gdt_term = TERM_SEL1;
      2'h2:    gdt_term = TERM_SEL2;
      default: gdt_term = TERM_SEL3;
    endcase
  endfunction

endpackage

// file: logic/gdt_pin_sync.sv
// Three-stage sampler for a pin from outside the clock domain.
// A change counts only once the second and third stages agree.
`timescale 1ns/1ps
module gdt_pin_sync (
  input  wire logic clock,
  input  wire logic rs_n,
  input  wire logic pin,
  output logic      lvl
);
  gdt_pkg::gdt_sync_type q;
  gdt_pkg::gdt_sync_type d;

  // First stage feeds only the second
  always_comb begin
    d    = q;
    d.s1 = pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge clock or negedge rs_n) begin
    if (!rs_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lvl = q.lvl;
endmodule

// file: logic/gdt_rst_sync.sv
// Reset release synchroniser for the guard timer.
// Assumes rst_n may fall at any time; release is aligned to clock.
`timescale 1ns/1ps
module gdt_rst_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      rs_n
);
  gdt_pkg::gdt_rsync_type q;
  gdt_pkg::gdt_rsync_type d;

  // Shift a one in after release
  always_comb begin
    d    = q;
    d.r1 = 1'b1;
    d.r2 = q.r1;
  end

  // Assert at once, release two edges later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rs_n = q.r2;
endmodule

// file: logic/gdt_timer.sv
// Guard timer: watchdog or interval timer on a 15-bit low-speed counter, APB registers.
// Assumes the low-speed oscillator is a slow pin, power mode comes from same-clock logic,
// and the chip answers sys_reset_req by resetting this block.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps

module gdt_timer (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ls_clk,
  input  wire logic [2:0]  pwr_mode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             sys_reset_req,
  output logic             guard_irq
);

  gdt_pkg::gdt_state_type q;
  gdt_pkg::gdt_state_type d;
  gdt_pkg::gdt_ctrl_type  wctrl;
  logic                   rs_n;
  logic                   ls_lvl;
  logic                   ls_rise;
  logic                   ls_any;
  logic                   acc_setup;
  logic                   acc_done;
  logic                   hit_ctrl;
  logic                   hit_stat;
  logic                   wr_ctrl;
  logic                   wr_stat;
  logic                   wdog;
  logic                   wdog_lock;
  logic                   deep;
  logic                   sleep1;
  logic                   tick;
  logic                   at_term;
  logic                   clr_wd;
  logic                   clr_tm;
  logic [31:0]            stat_word;

  // Reset release and low-speed clock sampling
  gdt_rst_sync u_rst (
    .clock (clock),
    .rst_n (rst_n),
    .rs_n  (rs_n)
  );

  gdt_pin_sync u_ls (
    .clock (clock),
    .rs_n  (rs_n),
    .pin   (ls_clk),
    .lvl   (ls_lvl)
  );

  // Slow-clock edges seen in the system domain
  assign ls_rise = ls_lvl & ~q.ls_prev;
  assign ls_any  = ls_lvl ^ q.ls_prev;

  // APB decode; one wait state so read data can come from a flop
  assign acc_setup = psel & penable & ~q.pready;
  assign acc_done  = psel & penable & q.pready;
  assign hit_ctrl  = (paddr == gdt_pkg::OFF_CTRL);
  assign hit_stat  = (paddr == gdt_pkg::OFF_STAT);
  assign wr_ctrl   = acc_done & pwrite & hit_ctrl;
  assign wr_stat   = acc_done & pwrite & hit_stat;
  assign wctrl     = gdt_pkg::gdt_ctrl_type'(pwdata[7:0]);

  // Mode and power qualifiers
  assign wdog      = (q.ctrl.mode == gdt_pkg::MODE_WDOG);
  assign wdog_lock = q.ctrl.en & wdog;
  assign deep      = (pwr_mode == gdt_pkg::PWR_MODE_2) | (pwr_mode == gdt_pkg::PWR_MODE_3);
  assign sleep1    = (pwr_mode == gdt_pkg::PWR_MODE_1);
  assign tick      = ls_rise & q.ctrl.en & ~deep;
  // Compare as at-or-above so a shortened interval still times out
  assign at_term   = (q.cnt >= gdt_pkg::gdt_term(q.ctrl.isel));

  // Clear requests; the key field only listens while enabled
  assign clr_wd = wr_ctrl & wdog_lock & (wctrl.key == gdt_pkg::KEY_SECOND)
                  & (q.armed == gdt_pkg::KEY_ARMED);
  assign clr_tm = wr_ctrl & q.ctrl.en & ~wdog & wctrl.key[0];

  // Status word: flag, enable, running, armed, expired-in-sleep
  always_comb begin
    stat_word = gdt_pkg::RDATA_RESET;
    stat_word[gdt_pkg::STAT_FLAG_BIT]  = q.irq_flag;
    stat_word[gdt_pkg::STAT_IEN_BIT]   = q.irq_en;
    stat_word[gdt_pkg::STAT_RUN_BIT]   = q.ctrl.en & ~deep;
    stat_word[gdt_pkg::STAT_ARMED_BIT] = (q.armed == gdt_pkg::KEY_ARMED);
    stat_word[gdt_pkg::STAT_EXP_BIT]   = q.expired;
  end

  // Next-state logic; later assignments take priority
  always_comb begin
    d           = q;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    d.rst_pulse = 1'b0;
    d.ls_prev   = ls_lvl;

    // Bus answer a cycle after the access phase opens
    if (acc_setup) begin
      d.pready  = 1'b1;
      d.pslverr = ~(hit_ctrl | hit_stat);
      d.prdata  = gdt_pkg::RDATA_RESET;
      if (hit_ctrl) begin
        d.prdata[7:0] = {q.ctrl.key, q.ctrl.en, q.ctrl.mode, q.ctrl.isel};
      end else if (hit_stat) begin
        d.prdata = stat_word;
      end
    end

    // The clear window lasts until the next slow-clock edge: half a period
    if (ls_any) begin
      d.armed = gdt_pkg::KEY_IDLE;
    end

    // Counting and terminal events
    if (!q.ctrl.en) begin
      d.cnt = gdt_pkg::CNT_RESET;
    end else if (tick) begin
      if (at_term) begin
        d.cnt = gdt_pkg::CNT_RESET;
        if (wdog) begin
          // In power_mode_1 the timeout is held back until wake
          if (sleep1) begin
            d.expired = 1'b1;
          end else begin
            d.rst_pulse = 1'b1;
          end
        end else begin
          d.irq_flag = 1'b1;
        end
      end else begin
        d.cnt = q.cnt + 15'h0001;
      end
    end

    // Held timeout fires once the chip leaves power_mode_1 for a mode other than deep sleep
    if (q.expired && !sleep1 && !deep) begin
      d.rst_pulse = 1'b1;
      d.expired   = 1'b0;
    end

    // Control register write
    if (wr_ctrl) begin
      d.ctrl.isel = wctrl.isel;
      if (!wdog_lock) begin
        d.ctrl.mode = wctrl.mode;
        d.ctrl.en   = wctrl.en;
        if (!q.ctrl.en && wctrl.en) begin
          d.cnt = gdt_pkg::CNT_RESET;
        end
      end
      if (q.ctrl.en) begin
        d.ctrl.key = wctrl.key;
        if (wdog) begin
          case (q.armed)
            gdt_pkg::KEY_IDLE: begin
              if (wctrl.key == gdt_pkg::KEY_FIRST) begin
                d.armed = gdt_pkg::KEY_ARMED;
              end
            end
            gdt_pkg::KEY_ARMED: begin
              // A wrong second key drops the sequence, except KEY_FIRST again, which keeps it armed
              d.armed = (wctrl.key == gdt_pkg::KEY_FIRST) ? gdt_pkg::KEY_ARMED : gdt_pkg::KEY_IDLE;
            end
            default: begin
              d.armed = gdt_pkg::KEY_IDLE;
            end
          endcase
        end
      end
    end

    // A completed clear beats a timeout in the same cycle
    if (clr_wd) begin
      d.cnt       = gdt_pkg::CNT_RESET;
      d.expired   = 1'b0;
      d.rst_pulse = 1'b0;
    end
    if (clr_tm) begin
      d.cnt = gdt_pkg::CNT_RESET;
    end

    // Status write: enable is plain, flag is write-one-to-clear, a new event wins
    if (wr_stat) begin
      d.irq_en = pwdata[gdt_pkg::STAT_IEN_BIT];
      if (pwdata[gdt_pkg::STAT_FLAG_BIT] && !(tick && at_term && !wdog)) begin
        d.irq_flag = 1'b0;
      end
    end

    // Deep sleep: counter and sequence cleared, configuration kept
    if (deep) begin
      d.cnt       = gdt_pkg::CNT_RESET;
      d.armed     = gdt_pkg::KEY_IDLE;
      d.expired   = 1'b0;
      d.rst_pulse = 1'b0;
    end

    // Interrupt only from timer mode
    d.irq = q.irq_flag & q.irq_en & ~wdog;
  end

  // Whole state registered together
  always_ff @(posedge clock or negedge rs_n) begin
    if (!rs_n) begin
      q         <= '0;
      q.ctrl    <= gdt_pkg::gdt_ctrl_type'(gdt_pkg::CTRL_RESET);
      q.cnt     <= gdt_pkg::CNT_RESET;
      q.armed   <= gdt_pkg::KEY_IDLE;
      q.prdata  <= gdt_pkg::RDATA_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign sys_reset_req = q.rst_pulse;
  assign guard_irq     = q.irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rs_n);

  a_enable_by_write: assert property (
    $rose(q.ctrl.en) |-> $past(wr_ctrl) && $past(pwdata[gdt_pkg::CTRL_EN_BIT]))
    else $error("enable rose without a write");

  a_count_step: assert property (
    tick && !at_term && !wr_ctrl && !deep |=> q.cnt == $past(q.cnt) + 15'h0001)
    else $error("counter did not step by one");

  a_deep_clears: assert property (
    deep |=> q.cnt == gdt_pkg::CNT_RESET && !q.expired)
    else $error("counter not cleared in deep sleep");

  a_wdog_locked: assert property (
    wdog_lock |=> q.ctrl.en && q.ctrl.mode == gdt_pkg::MODE_WDOG)
    else $error("locked watchdog was disabled or changed mode");

  a_isel_write: assert property (
    wr_ctrl |=> q.ctrl.isel == $past(pwdata[1:0]))
    else $error("interval write lost");

  a_wdog_timeout: assert property (
    tick && at_term && wdog && !sleep1 && !clr_wd |=> sys_reset_req ##1 !sys_reset_req)
    else $error("watchdog timeout gave no single reset pulse");

  a_clear_seq: assert property (
    clr_wd |=> q.cnt == gdt_pkg::CNT_RESET && !sys_reset_req)
    else $error("valid clear did not zero the counter");

  a_window_closes: assert property (
    q.armed == gdt_pkg::KEY_ARMED && ls_any && !wr_ctrl |=> q.armed == gdt_pkg::KEY_IDLE)
    else $error("clear window outlived half a slow period");

  a_reset_source: assert property (
    sys_reset_req |-> $past(wdog_lock) && !$past(deep))
    else $error("reset raised outside watchdog mode");

  a_wdog_no_irq: assert property (
    $rose(q.irq_flag) |-> $past(q.ctrl.mode) == gdt_pkg::MODE_TIMER)
    else $error("interrupt flag set in watchdog mode");

  a_timer_flag: assert property (
    tick && at_term && !wdog |=> q.irq_flag ##1 (guard_irq == q.irq_en || $past(wr_stat)))
    else $error("timer terminal count did not raise the flag");

  a_pm1_hold: assert property (
    tick && at_term && wdog && sleep1 && !clr_wd |=> !sys_reset_req && q.expired)
    else $error("power_mode_1 timeout not held back");

  a_timer_stop: assert property (
    !q.ctrl.en |=> q.cnt == gdt_pkg::CNT_RESET)
    else $error("stopped timer kept a count");

  a_key_ignored: assert property (
    wr_ctrl && !q.ctrl.en |=> q.ctrl.key == $past(q.ctrl.key))
    else $error("key accepted while disabled");

  a_timer_clear: assert property (
    clr_tm |=> q.cnt == gdt_pkg::CNT_RESET)
    else $error("timer clear did not zero the counter");

  a_wdog_start: assert property (
    wr_ctrl && !q.ctrl.en && wctrl.en |=> q.ctrl.en && q.cnt == gdt_pkg::CNT_RESET)
    else $error("enable write did not start from zero");

  a_timer_no_reset: assert property (
    tick && at_term && !wdog |=> !sys_reset_req)
    else $error("timer terminal count raised a reset");

  a_wdog_irq_low: assert property (
    wdog |=> !guard_irq)
    else $error("interrupt raised in watchdog mode");

  a_cfg_kept: assert property (
    deep && !wr_ctrl |=> q.ctrl == $past(q.ctrl))
    else $error("deep sleep changed the configuration");

  a_flag_kept: assert property (
    q.irq_flag && !wr_stat |=> q.irq_flag)
    else $error("interrupt flag dropped without a write");

  a_pm1_wake: assert property (
    q.expired && !sleep1 && !deep && !clr_wd |=> sys_reset_req)
    else $error("held timeout did not fire on wake");

  a_disabled_quiet: assert property (
    !q.ctrl.en && !q.expired |=> !sys_reset_req)
    else $error("reset raised while disabled");

endmodule
